/* File: msra_pkg.sv */
// Shared constants and types for the meter serial register access block
`default_nettype none

package msra_pkg;

  // Register addresses
  localparam logic [5:0] MSRA_ADDR_MODE = 6'h09;
  localparam logic [5:0] MSRA_ADDR_TEMP = 6'h26;
  localparam logic [5:0] MSRA_ADDR_PERIOD = 6'h27;
  localparam logic [5:0] MSRA_ADDR_TEST = 6'h3d;
  localparam logic [5:0] MSRA_ADDR_ONES = 6'h3e;
  localparam logic [5:0] MSRA_ADDR_REV = 6'h3f;

  // Reset values
  localparam logic [15:0] MSRA_MODE_RST = 16'h000c;
  localparam logic [7:0] MSRA_TEST_RST = 8'h00;
  localparam logic [7:0] MSRA_TEMP_RST = 8'h00;
  localparam logic [15:0] MSRA_PERIOD_RST = 16'h0000;
  localparam logic [5:0] MSRA_ONES_RST = 6'h00;

  // Command byte layout
  localparam int MSRA_CMD_BITS = 8;
  localparam int MSRA_CMD_DIR_BIT = 7;
  localparam int MSRA_CMD_ADDR_MSB = 5;

  // Shift register width covers the widest register here
  localparam int MSRA_DATA_BITS = 16;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic din;
  } msra_link_type;

  typedef struct packed {
    logic [10:0] upper;
    logic converter_suspend;
    logic sag_output_off;
    logic pulse_output_off;
    logic power_lowpass_bypass;
    logic current_highpass_bypass;
  } msra_mode_type;

  typedef enum logic [1:0] {
    MSRA_ST_CMD = 2'b00,
    MSRA_ST_WRITE = 2'b01,
    MSRA_ST_READ = 2'b10
  } msra_state_type;

endpackage

`default_nettype wire

/* File: msra_pin_sync.sv */
// Two-stage synchroniser with edge detection for the serial pins
`default_nettype none

module msra_pin_sync
  import msra_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire msra_link_type pins,
  output msra_link_type level,
  output logic sclk_rise,
  output logic sclk_fall
);

  msra_link_type meta_r, meta_nxt;
  msra_link_type sync_r, sync_nxt;
  logic sclk_old_r, sclk_old_nxt;

  always_comb
  begin
    meta_nxt = pins;
    sync_nxt = meta_r;
    sclk_old_nxt = sync_r.sclk;
  end

  // Idle pin levels: clock low, select high
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      meta_r <= '{sclk: 1'b0, cs_n: 1'b1, din: 1'b0};
      sync_r <= '{sclk: 1'b0, cs_n: 1'b1, din: 1'b0};
      sclk_old_r <= 1'b0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      sclk_old_r <= sclk_old_nxt;
    end
  end

  assign level = sync_r;
  assign sclk_rise = sync_r.sclk & ~sclk_old_r;
  assign sclk_fall = ~sync_r.sclk & sclk_old_r;

endmodule // msra_pin_sync

`default_nettype wire

/* File: msra_ones_tally.sv */
// Counts one bits shifted out during a read and latches the total
`default_nettype none

module msra_ones_tally
  import msra_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic bit_valid,
  input wire logic bit_value,
  input wire logic capture,
  output logic [5:0] total
);

  logic [5:0] run_r, run_nxt;
  logic [5:0] total_r, total_nxt;

  always_comb
  begin
    run_nxt = run_r;
    total_nxt = total_r;
    if (clear)
      run_nxt = MSRA_ONES_RST;
    else if (bit_valid && bit_value)
      run_nxt = run_r + 6'h01;
    if (capture)
      total_nxt = run_r;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      run_r <= MSRA_ONES_RST;
      total_r <= MSRA_ONES_RST;
    end
    else
    begin
      run_r <= run_nxt;
      total_r <= total_nxt;
    end
  end

  assign total = total_r;

endmodule // msra_ones_tally

`default_nettype wire

/* File: msra_top.sv */
// Serial register access front end and upper register map of the meter
// How it works
// - Temperature register holds latest signed conversion
// - Period register read-only, top bit zero
// - Checksum counts ones of previous read
// - Revision register returns fixed number
// - First byte of every transfer is command
// - Command byte is write-only, never read
// - Command bits 0-5 select the register
// - Bit 7 set: next transfer writes
// - Bit 7 clear: next transfer reads
// - Mode register at 0x09 sets configuration
// - Mode bit 1 bypasses power low-pass
// - Mode bit 4 powers down both converters
// - Stopped input clock freezes all state
`default_nettype none

module msra_top
  import msra_pkg::*;
#(
  parameter logic [7:0] SILICON_REVISION = 8'h5a // Arbitrary value
)
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic din_pin,
  output logic dout_pin,
  output logic dout_oe,
  input wire logic [7:0] temperature_in,
  input wire logic temperature_valid,
  input wire logic [15:0] period_in,
  input wire logic period_valid,
  output logic current_highpass_bypass,
  output logic power_lowpass_bypass,
  output logic pulse_output_off,
  output logic sag_output_off,
  output logic converter_suspend,
  output logic [10:0] mode_upper,
  output logic [7:0] test_config
);

  msra_link_type pins;
  msra_link_type lvl;
  logic sclk_rise;
  logic sclk_fall;
  logic [5:0] ones_total;

  assign pins = '{sclk: sclk_pin, cs_n: cs_n_pin, din: din_pin};

  msra_pin_sync u_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pins(pins),
    .level(lvl),
    .sclk_rise(sclk_rise),
    .sclk_fall(sclk_fall)
  );

  // Transfer state
  msra_state_type st_r, st_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic [5:0] addr_r, addr_nxt;
  logic [15:0] wsh_r, wsh_nxt;
  logic [15:0] rsh_r, rsh_nxt;
  logic dout_r, dout_nxt;
  logic [4:0] nbits;
  logic cmd_done;
  logic wr_commit;
  logic rd_done;
  logic rd_start;
  logic shift_out;
  logic [15:0] wr_data;
  logic [15:0] rd_value;

  // Register state
  msra_mode_type mode_r, mode_nxt;
  logic [7:0] test_r, test_nxt;
  logic [7:0] temp_r, temp_nxt;
  logic [15:0] period_r, period_nxt;

  // Transfer length in bits: whole bytes from register width
  function automatic logic [4:0] xfer_bits(input logic [5:0] a);
    if (a == MSRA_ADDR_MODE || a == MSRA_ADDR_PERIOD)
      xfer_bits = 5'h10;
    else
      xfer_bits = 5'h08;
  endfunction

  // Unlisted addresses read as zero
  function automatic logic [15:0] read_mux(
    input logic [5:0] a,
    input msra_mode_type m,
    input logic [7:0] t,
    input logic [7:0] tp,
    input logic [15:0] p,
    input logic [5:0] o
  );
    if (a == MSRA_ADDR_MODE)
      read_mux = m;
    else if (a == MSRA_ADDR_TEMP)
      read_mux = {8'h00, tp};
    else if (a == MSRA_ADDR_PERIOD)
      read_mux = p;
    else if (a == MSRA_ADDR_TEST)
      read_mux = {8'h00, t};
    else if (a == MSRA_ADDR_ONES)
      read_mux = {10'h000, o};
    else if (a == MSRA_ADDR_REV)
      read_mux = {8'h00, SILICON_REVISION};
    else
      read_mux = 16'h0000;
  endfunction

  assign nbits = xfer_bits(addr_r);
  // Address built from the stored bits plus the incoming one, so no loop through cmd_nxt
  assign rd_value = read_mux({cmd_r[4:0], lvl.din}, mode_r, test_r, temp_r, period_r, ones_total);

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    cmd_nxt = cmd_r;
    addr_nxt = addr_r;
    wsh_nxt = wsh_r;
    rsh_nxt = rsh_r;
    dout_nxt = dout_r;
    cmd_done = 1'b0;
    wr_commit = 1'b0;
    rd_done = 1'b0;
    rd_start = 1'b0;
    shift_out = 1'b0;
    wr_data = {wsh_r[14:0], lvl.din};
    if (lvl.cs_n)
    begin
      // Deselect aborts; next selection begins with a command
      st_nxt = MSRA_ST_CMD;
      cnt_nxt = 5'h00;
      dout_nxt = 1'b0;
    end
    else
    begin
      case (st_r)
        MSRA_ST_CMD:
        begin
          if (sclk_fall)
          begin
            cmd_nxt = {cmd_r[6:0], lvl.din};
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == 5'(MSRA_CMD_BITS - 1))
            begin
              cmd_done = 1'b1;
              cnt_nxt = 5'h00;
              // Bit 6 is ignored; host keeps it zero
              addr_nxt = cmd_nxt[MSRA_CMD_ADDR_MSB:0];
              wsh_nxt = 16'h0000;
              if (cmd_nxt[MSRA_CMD_DIR_BIT])
                st_nxt = MSRA_ST_WRITE;
              else
              begin
                st_nxt = MSRA_ST_READ;
                rd_start = 1'b1;
                // Left align so the top byte leaves first
                if (xfer_bits(cmd_nxt[MSRA_CMD_ADDR_MSB:0]) == 5'h10)
                  rsh_nxt = rd_value;
                else
                  rsh_nxt = {rd_value[7:0], 8'h00};
              end
            end
          end
        end
        MSRA_ST_WRITE:
        begin
          if (sclk_fall)
          begin
            wsh_nxt = wr_data;
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == nbits - 5'h01)
            begin
              wr_commit = 1'b1;
              cnt_nxt = 5'h00;
              st_nxt = MSRA_ST_CMD;
            end
          end
        end
        MSRA_ST_READ:
        begin
          // Drive on rising edge so the host samples on falling
          if (sclk_rise)
          begin
            shift_out = 1'b1;
            dout_nxt = rsh_r[15];
            rsh_nxt = {rsh_r[14:0], 1'b0};
          end
          if (sclk_fall)
          begin
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == nbits - 5'h01)
            begin
              rd_done = 1'b1;
              cnt_nxt = 5'h00;
              st_nxt = MSRA_ST_CMD;
            end
          end
        end
        default:
        begin
          st_nxt = MSRA_ST_CMD;
          cnt_nxt = 5'h00;
        end
      endcase
    end
  end

  // All state lives on mclk, so a stopped clock freezes it
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_r <= MSRA_ST_CMD;
      cnt_r <= 5'h00;
      cmd_r <= 8'h00;
      addr_r <= 6'h00;
      wsh_r <= 16'h0000;
      rsh_r <= 16'h0000;
      dout_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      cmd_r <= cmd_nxt;
      addr_r <= addr_nxt;
      wsh_r <= wsh_nxt;
      rsh_r <= rsh_nxt;
      dout_r <= dout_nxt;
    end
  end

  msra_ones_tally u_tally (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clear(rd_start),
    .bit_valid(shift_out),
    .bit_value(rsh_r[15]),
    .capture(rd_done),
    .total(ones_total)
  );

  // Register file
  always_comb
  begin
    mode_nxt = mode_r;
    test_nxt = test_r;
    temp_nxt = temp_r;
    period_nxt = period_r;
    if (wr_commit && addr_r == MSRA_ADDR_MODE)
      mode_nxt = wr_data;
    if (wr_commit && addr_r == MSRA_ADDR_TEST)
      test_nxt = wr_data[7:0];
    if (temperature_valid)
      temp_nxt = temperature_in;
    if (period_valid)
      period_nxt = {1'b0, period_in[14:0]};
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      mode_r <= MSRA_MODE_RST;
      test_r <= MSRA_TEST_RST;
      temp_r <= MSRA_TEMP_RST;
      period_r <= MSRA_PERIOD_RST;
    end
    else
    begin
      mode_r <= mode_nxt;
      test_r <= test_nxt;
      temp_r <= temp_nxt;
      period_r <= period_nxt;
    end
  end

  // Only the read phase drives the pin, so the command is never echoed
  assign dout_oe = (st_r == MSRA_ST_READ);
  assign dout_pin = dout_r;
  assign current_highpass_bypass = mode_r.current_highpass_bypass;
  assign power_lowpass_bypass = mode_r.power_lowpass_bypass;
  assign pulse_output_off = mode_r.pulse_output_off;
  assign sag_output_off = mode_r.sag_output_off;
  assign converter_suspend = mode_r.converter_suspend;
  assign mode_upper = mode_r.upper;
  assign test_config = test_r;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence cmd_last_bit;
    st_r == MSRA_ST_CMD && !lvl.cs_n && sclk_fall && cnt_r == 5'h07;
  endsequence

  sequence write_end;
    wr_commit && addr_r == MSRA_ADDR_MODE;
  endsequence

  temp_capture_a: assert property (temperature_valid |=> temp_r == $past(temperature_in))
    else $error("temperature not captured");
  period_msb_a: assert property (period_r[15] == 1'b0)
    else $error("period top bit set");
  ones_latch_a: assert property (rd_done |=> ones_total == $past(u_tally.run_r))
    else $error("checksum not latched");
  rev_read_a: assert property (cmd_last_bit ##0 (cmd_nxt == {2'b00, MSRA_ADDR_REV})
    |=> rsh_r == {SILICON_REVISION, 8'h00})
    else $error("revision load wrong");
  cmd_leaves_a: assert property (cmd_last_bit |=> st_r != MSRA_ST_CMD && addr_r == $past(cmd_nxt[5:0]))
    else $error("command not consumed");
  no_cmd_echo_a: assert property (dout_oe |-> st_r == MSRA_ST_READ && !$past(lvl.cs_n))
    else $error("pin driven outside read");
  dir_write_a: assert property (cmd_last_bit ##0 cmd_nxt[7] |=> st_r == MSRA_ST_WRITE)
    else $error("write not entered");
  dir_read_a: assert property (cmd_last_bit ##0 !cmd_nxt[7] |=> st_r == MSRA_ST_READ ##1 dout_oe)
    else $error("read not entered");
  mode_write_a: assert property (write_end |=> mode_r == $past(wr_data))
    else $error("mode write lost");
  lowpass_out_a: assert property (##1 power_lowpass_bypass == mode_r[1] && converter_suspend == mode_r[4])
    else $error("mode outputs mismatch");
  mode_reset_a: assert property (disable iff (1'b0) sys_rst |=> pulse_output_off && sag_output_off
    && !current_highpass_bypass)
    else $error("mode reset value wrong");
  byte_count_a: assert property (rd_done |-> cnt_r == nbits - 5'h01 && (nbits == 5'h08 || nbits == 5'h10))
    else $error("read length not whole bytes");

endmodule // msra_top

`default_nettype wire

/* File: msra_host_model.sv */
// Host side model that drives the serial link of the register block
`default_nettype none

module msra_host_model
(
  output var logic sclk,
  output var logic cs_n,
  output var logic din,
  input wire logic dout
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b0;
  end

  // Write data left-justified, read data returned right-justified
  task automatic xfer(input logic [7:0] cmd, input int nbits, input logic [15:0] wdata,
                      output logic [15:0] rdata);
    logic [23:0] sh;
    sh = {cmd & 8'hbf, wdata};
    rdata = 16'h0000;
    cs_n = 1'b0;
    #100;
    // Command byte first, then data bytes, MSB first
    for (int i = 0; i < 8 + nbits; i++)
    begin
      // Data moves mid-low so it stands still across the falling edge
      #31.25 din = sh[23 - i];
      #31.25 sclk = 1'b1;
      #62.5;
      if (i >= 8)
        rdata = {rdata[14:0], dout};
      sclk = 1'b0;
    end
    #100 cs_n = 1'b1;
    // Released line flips so a stale bit is never mistaken for data
    din = ~din;
  endtask
endmodule // msra_host_model
`default_nettype wire

/* File: test_meter_serial_register_access.sv */
// Self-checking bench for the meter serial register access block
`default_nettype none

`define CHECK_EQ(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module test_meter_serial_register_access
  import msra_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [7:0] cmd;
    int nbits;
    logic [15:0] wdata;
    logic [15:0] expect_val;
  } msra_tb_row_type;

  localparam logic [7:0] REV = 8'h5a; // Arbitrary value
  msra_tb_row_type rows [14] = '{
    '{8'h09, 16, 16'h0000, 16'h000c},
    '{8'h26, 8, 16'h0000, 16'h0000},
    '{8'h27, 16, 16'h0000, 16'h0000},
    '{8'h3f, 8, 16'h0000, {8'h00, REV}},
    '{8'h89, 16, 16'h0013, 16'h0000},
    '{8'h09, 16, 16'h0000, 16'h0013},
    '{8'h3e, 8, 16'h0000, 16'h0003},
    '{8'hbd, 8, 16'ha500, 16'h0000},
    '{8'h3d, 8, 16'h0000, 16'h00a5},
    '{8'h3e, 8, 16'h0000, 16'h0004},
    '{8'hbf, 8, 16'h0000, 16'h0000},
    '{8'h3f, 8, 16'h0000, {8'h00, REV}},
    '{8'h30, 8, 16'h0000, 16'h0000},
    '{8'h3e, 8, 16'h0000, 16'h0000}
  };

  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_hold = 1'b0;
  logic sclk, cs_n, din, dout, dout_oe;
  logic [7:0] temperature_in = 8'h00;
  logic temperature_valid = 1'b0;
  logic [15:0] period_in = 16'h0000;
  logic period_valid = 1'b0;
  logic hp_byp, lp_byp, pulse_off, sag_off, suspend;
  logic [10:0] mode_upper;
  logic [7:0] test_config;
  logic [15:0] rd;
  wire [4:0] mode_low;
  int err_count = 0;
  int compares = 0;
  int cycles = 0;

  assign mode_low = {suspend, sag_off, pulse_off, lp_byp, hp_byp};

  // Holding the clock models a stopped master clock input
  always #5 mclk = clk_hold ? mclk : ~mclk;

  msra_top #(.SILICON_REVISION(REV)) dut (
    .mclk(mclk), .sys_rst(sys_rst), .sclk_pin(sclk), .cs_n_pin(cs_n), .din_pin(din),
    .dout_pin(dout), .dout_oe(dout_oe), .temperature_in(temperature_in),
    .temperature_valid(temperature_valid), .period_in(period_in), .period_valid(period_valid),
    .current_highpass_bypass(hp_byp), .power_lowpass_bypass(lp_byp), .pulse_output_off(pulse_off),
    .sag_output_off(sag_off), .converter_suspend(suspend), .mode_upper(mode_upper),
    .test_config(test_config)
  );

  // Undriven data line reads high, so a missing drive shows up in the data
  msra_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout_oe ? dout : 1'b1));

  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic run(input logic [7:0] cmd, input int nbits, input logic [15:0] wdata);
    @(posedge mclk);
    #1;
    host.xfer(cmd, nbits, wdata, rd);
    repeat (4) @(posedge mclk);
    #1;
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      summarize();
    end
  end

  initial
  begin
    repeat (20) @(posedge mclk);
    #1 sys_rst = 1'b0;
    repeat (4) @(posedge mclk);
    `CHECK_EQ(dout_oe, 1'b0)
    foreach (rows[i])
    begin
      run(rows[i].cmd, rows[i].nbits, rows[i].wdata);
      if (!rows[i].cmd[7])
        `CHECK_EQ(rd, rows[i].expect_val)
    end
    `CHECK_EQ(mode_low, 5'h13)
    end_test("table");
    @(posedge mclk);
    #1;
    temperature_in = 8'hf3;
    temperature_valid = 1'b1;
    period_in = 16'hffff;
    period_valid = 1'b1;
    @(posedge mclk);
    #1;
    temperature_valid = 1'b0;
    period_valid = 1'b0;
    run(8'h26, 8, 16'h0000);
    `CHECK_EQ(rd, 16'h00f3)
    run(8'h27, 16, 16'h0000);
    `CHECK_EQ(rd, 16'h7fff)
    end_test("measurements");
    // Aborted write must leave the mode alone
    run(8'h89, 8, 16'hff00);
    run(8'h09, 16, 16'h0000);
    `CHECK_EQ(rd, 16'h0013)
    run(8'h89, 16, 16'h000c);
    `CHECK_EQ(mode_low, 5'h0c)
    end_test("abort");
    @(posedge mclk);
    #1 clk_hold = 1'b1;
    host.xfer(8'h89, 16, 16'h0013, rd);
    clk_hold = 1'b0;
    repeat (4) @(posedge mclk);
    `CHECK_EQ(mode_low, 5'h0c)
    end_test("clock stop");
    run(8'h89, 16, 16'hffe3);
    `CHECK_EQ({mode_upper, mode_low}, 16'hffe3)
    #1 sys_rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1 sys_rst = 1'b0;
    @(posedge mclk);
    #1;
    `CHECK_EQ(test_config, 8'h00)
    `CHECK_EQ({mode_upper, mode_low}, 16'h000c)
    `CHECK_EQ(dout_oe, 1'b0)
    end_test("reset");
    summarize();
  end
endmodule // test_meter_serial_register_access
`default_nettype wire
